// *** sda_map.svh ***
// Constants of the sigma-delta converter control block
// Functional notes
// - Unipolar gives straight binary, zero at bottom
// - Bipolar gives offset binary, zero at midpoint
// - Modulator bit sampled at clock over 128, over 256 with clock divide bit set
// - Third-order sinc decimation filter on stream
// - Output word rate equals first notch
// - Cutoff is 0.262 of first notch
// - Rate selects move notches, same shape
// - Step settles within four output periods
// - Three periods after sync hold released
// - Chip select high floats output, ignores clock
// - Sample input rising, change output falling
// - All shifting is most significant first
// - Works with chip select tied low
// - Seven registers, full-width transfers
// - 16-bit result, 24-bit offset and gain
// - 8-bit setup and clock registers
// - Idle device takes next byte as command
// - Command byte first, then register transfer
// - After data step, wait for command
// - 32 ones resynchronise, registers kept
// - Ready low on result, high after read
// - Command bit: zero write, one read
// - Sync hold resets filter and modulator path
`ifndef SDA_MAP_SVH
`define SDA_MAP_SVH
`define SDA_RS_COMM    3'h0
`define SDA_RS_SETUP   3'h1
`define SDA_RS_CLOCK   3'h2
`define SDA_RS_DATA    3'h3
`define SDA_RS_TEST    3'h4
`define SDA_RS_NOP     3'h5
`define SDA_RS_OFFSET  3'h6
`define SDA_RS_GAIN    3'h7
`define SDA_CMD_RW     3
`define SDA_CMD_PD     2
`define SDA_SET_UNI    2
`define SDA_SET_BUF    1
`define SDA_SET_HOLD   0
`define SDA_CLK_DIS    4
`define SDA_CLK_DIV    3
`define SDA_CLK_RANGE  2
`define SDA_COMM_RST   8'h00
`define SDA_SETUP_RST  8'h01
`define SDA_CLOCK_RST  8'h05
`define SDA_OFFSET_RST 24'h1f4000
`define SDA_GAIN_RST   24'h5761ab
`define SDA_MOD_DIV    8'd128
`define SDA_SETTLE     2'd3
`define SDA_RESYNC     6'd32
`endif

// *** sda_pkg.sv ***
// Types of the sigma-delta converter control block
package sda_pkg;
  typedef enum logic [1:0] {
    SDA_IDLE = 2'b00,
    SDA_CMD  = 2'b01,
    SDA_WR   = 2'b10,
    SDA_RD   = 2'b11
  } sda_state_t;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } sda_ser_in_t;
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } sda_ser_out_t;
endpackage : sda_pkg

// *** sda_ctrl.sv ***
// Serial port, registers and sinc3 decimator of the converter
`timescale 1ns/1ns
`include "sda_map.svh"
module sda_ctrl #(
  parameter int ACC_W = 32
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 clk_en,
  input  wire sda_pkg::sda_ser_in_t ser_in,
  output sda_pkg::sda_ser_out_t     ser_out,
  input  wire logic                 mod_bit,
  output logic                      data_ready_n,
  output logic [1:0]                channel_select,
  output logic [2:0]                gain_select,
  output logic [1:0]                cal_mode,
  output logic                      buffer_enable,
  output logic                      power_down,
  output logic                      clock_out_disable
);
  // Accumulators must hold the cubic growth of the decimator
  if (ACC_W < 28) begin : g_acc_check
    $error("ACC_W too small for sinc3 growth");
  end

  sda_pkg::sda_state_t st_ff, nxt_st;
  logic        sclk_q_ff, nxt_sclk_q;
  logic [4:0]  bit_cnt_ff, nxt_bit_cnt;
  logic [5:0]  ones_ff, nxt_ones;
  logic [23:0] in_sh_ff, nxt_in_sh, out_sh_ff, nxt_out_sh;
  logic        dout_ff, nxt_dout;
  logic [7:0]  comm_ff, nxt_comm, setup_ff, nxt_setup;
  logic [7:0]  clock_ff, nxt_clock, test_ff, nxt_test;
  logic [23:0] ofs_ff [3], nxt_ofs [3], gn_ff [3], nxt_gn [3];
  logic        data_ready_n_n_ff, nxt_data_ready_n_n;
  logic [15:0] data_ff, nxt_data;
  logic        rise, fall, rd_done;
  logic [4:0]  width;
  logic [1:0]  pair;
  logic [7:0]  cmd;
  logic [23:0] wval;

  // Register width of the selected register
  function automatic logic [4:0] reg_width(input logic [2:0] rs);
    case (rs)
      `SDA_RS_DATA:   reg_width = 5'd16;
      `SDA_RS_OFFSET: reg_width = 5'd24;
      `SDA_RS_GAIN:   reg_width = 5'd24;
      `SDA_RS_NOP:    reg_width = 5'd0;
      default:        reg_width = 5'd8;
    endcase
  endfunction : reg_width

  // Channel to offset/gain pair
  function automatic logic [1:0] pair_of(input logic [1:0] ch);
    pair_of = (ch == 2'b01) ? 2'd1 : (ch == 2'b11) ? 2'd2 : 2'd0;
  endfunction : pair_of

  // Edges count only while selected, so a tied-low select works too
  assign rise = clk_en & ~ser_in.cs_n & ser_in.sclk & ~sclk_q_ff;
  assign fall = clk_en & ~ser_in.cs_n & ~ser_in.sclk & sclk_q_ff;
  assign width = reg_width(comm_ff[6:4]);
  assign pair = pair_of(comm_ff[1:0]);
  assign cmd = {in_sh_ff[6:0], ser_in.din};
  assign wval = {in_sh_ff[22:0], ser_in.din};
  assign rd_done = rise & (st_ff == sda_pkg::SDA_RD)
                   & (bit_cnt_ff == width - 5'd1);

  // Filter side signals
  logic             mod_stb, new_res;
  logic [15:0]      res_code;

  // Serial engine and register file next state
  always_comb begin
    nxt_st = st_ff;
    nxt_sclk_q = ser_in.sclk;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_ones = ones_ff;
    nxt_in_sh = in_sh_ff;
    nxt_out_sh = out_sh_ff;
    nxt_dout = dout_ff;
    nxt_comm = comm_ff;
    nxt_setup = setup_ff;
    nxt_clock = clock_ff;
    nxt_test = test_ff;
    nxt_ofs = ofs_ff;
    nxt_gn = gn_ff;
    nxt_data = data_ff;
    nxt_data_ready_n_n = data_ready_n_n_ff;
    if (rise) begin
      nxt_in_sh = wval;
      nxt_bit_cnt = bit_cnt_ff + 5'd1;
      case (st_ff)
        sda_pkg::SDA_IDLE: begin
          if (!ser_in.din) begin
            nxt_st = sda_pkg::SDA_CMD;
            nxt_bit_cnt = 5'd1;
          end
        end
        sda_pkg::SDA_CMD: begin
          if (bit_cnt_ff == 5'd7) begin
            nxt_comm = {1'b0, cmd[6:0]};
            nxt_bit_cnt = 5'd0;
            if (cmd[6:4] == `SDA_RS_NOP) begin
              nxt_st = sda_pkg::SDA_IDLE;
            end else if (cmd[`SDA_CMD_RW]) begin
              nxt_st = sda_pkg::SDA_RD;
              case (cmd[6:4])
                `SDA_RS_COMM:  nxt_out_sh = {data_ready_n_n_ff, cmd[6:0], 16'h0000};
                `SDA_RS_SETUP: nxt_out_sh = {setup_ff, 16'h0000};
                `SDA_RS_CLOCK: nxt_out_sh = {3'h0, clock_ff[4:0], 16'h0000};
                `SDA_RS_DATA:  nxt_out_sh = {data_ff, 8'h00};
                `SDA_RS_TEST:  nxt_out_sh = {test_ff, 16'h0000};
                `SDA_RS_OFFSET: nxt_out_sh = ofs_ff[pair_of(cmd[1:0])];
                default:       nxt_out_sh = gn_ff[pair_of(cmd[1:0])];
              endcase
            end else if (cmd[6:4] == `SDA_RS_COMM) begin
              nxt_st = sda_pkg::SDA_IDLE;
            end else begin
              nxt_st = sda_pkg::SDA_WR;
            end
          end
        end
        sda_pkg::SDA_WR: begin
          if (bit_cnt_ff == width - 5'd1) begin
            nxt_st = sda_pkg::SDA_IDLE;
            case (comm_ff[6:4])
              `SDA_RS_SETUP:  nxt_setup = wval[7:0];
              `SDA_RS_CLOCK:  nxt_clock = {3'h0, wval[4:0]};
              `SDA_RS_TEST:   nxt_test = wval[7:0];
              `SDA_RS_OFFSET: nxt_ofs[pair] = wval;
              `SDA_RS_GAIN:   nxt_gn[pair] = wval;
              default:        nxt_test = test_ff;
            endcase
          end
        end
        sda_pkg::SDA_RD: begin
          if (rd_done) nxt_st = sda_pkg::SDA_IDLE;
        end
        default: nxt_st = sda_pkg::SDA_IDLE;
      endcase
      // Thirty-two ones in a row drop framing, registers untouched
      nxt_ones = ser_in.din ? ones_ff + 6'd1 : 6'd0;
      if (ser_in.din && ones_ff == `SDA_RESYNC - 6'd1) begin
        nxt_st = sda_pkg::SDA_IDLE;
        nxt_ones = 6'd0;
        nxt_comm = comm_ff;
        nxt_setup = setup_ff;
        nxt_clock = clock_ff;
        nxt_test = test_ff;
        nxt_ofs = ofs_ff;
        nxt_gn = gn_ff;
      end
    end
    // Read data leaves on falling edges, first one after the command
    if (fall && st_ff == sda_pkg::SDA_RD) begin
      nxt_dout = out_sh_ff[23];
      nxt_out_sh = {out_sh_ff[22:0], 1'b0};
    end
    // Full data word read clears ready; a new result wins
    if (rd_done && comm_ff[6:4] == `SDA_RS_DATA) nxt_data_ready_n_n = 1'b1;
    if (new_res) begin
      nxt_data = res_code;
      nxt_data_ready_n_n = 1'b0;
    end
  end

  // Serial engine and register file state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_ff <= sda_pkg::SDA_IDLE;
      sclk_q_ff <= 1'b1;                 // Idle level, no false edge
      bit_cnt_ff <= 5'd0;
      ones_ff <= 6'd0;
      in_sh_ff <= 24'h000000;
      out_sh_ff <= 24'h000000;
      dout_ff <= 1'b0;
      comm_ff <= `SDA_COMM_RST;
      setup_ff <= `SDA_SETUP_RST;
      clock_ff <= `SDA_CLOCK_RST;
      test_ff <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        ofs_ff[i] <= `SDA_OFFSET_RST;
        gn_ff[i] <= `SDA_GAIN_RST;
      end
      data_ff <= 16'h0000;
      data_ready_n_n_ff <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      sclk_q_ff <= nxt_sclk_q;
      bit_cnt_ff <= nxt_bit_cnt;
      ones_ff <= nxt_ones;
      in_sh_ff <= nxt_in_sh;
      out_sh_ff <= nxt_out_sh;
      dout_ff <= nxt_dout;
      comm_ff <= nxt_comm;
      setup_ff <= nxt_setup;
      clock_ff <= nxt_clock;
      test_ff <= nxt_test;
      ofs_ff <= nxt_ofs;
      gn_ff <= nxt_gn;
      data_ff <= nxt_data;
      data_ready_n_n_ff <= nxt_data_ready_n_n;
    end
  end

  // Pins and control outputs
  assign ser_out.dout = dout_ff;
  assign ser_out.dout_oe = ~ser_in.cs_n;
  assign data_ready_n = data_ready_n_n_ff;
  assign channel_select = comm_ff[1:0];
  assign power_down = comm_ff[`SDA_CMD_PD];
  assign cal_mode = setup_ff[7:6];
  assign gain_select = setup_ff[5:3];
  assign buffer_enable = setup_ff[`SDA_SET_BUF];
  assign clock_out_disable = clock_ff[`SDA_CLK_DIS];

  // Filter state
  logic             hold;
  logic [7:0]       div_ff, nxt_div;
  logic [8:0]       dec_ff, nxt_dec;
  logic [1:0]       settle_ff, nxt_settle;
  logic [ACC_W-1:0] integ_ff [3], nxt_integ [3];
  logic [ACC_W-1:0] comb_ff [3], nxt_comb [3];
  logic [ACC_W-1:0] raw, cd;
  logic [3:0]       lg;
  logic [16:0]      scaled;

  assign hold = setup_ff[`SDA_SET_HOLD];
  // Decimation is a power of two picked by range and rate selects
  assign lg = clock_ff[`SDA_CLK_RANGE] ? 4'd9 - {2'b00, clock_ff[1:0]}
                                       : 4'd8 - {2'b00, clock_ff[1:0]};
  assign mod_stb = clk_en & ~hold & ~power_down & (div_ff ==
                   (clock_ff[`SDA_CLK_DIV] ? 8'd255 : `SDA_MOD_DIV - 8'd1));

  // Sinc3 next state: integrators per sample, combs per output
  always_comb begin
    nxt_div = div_ff + 8'd1;
    if (mod_stb) nxt_div = 8'd0;
    nxt_dec = dec_ff;
    nxt_settle = settle_ff;
    nxt_integ = integ_ff;
    nxt_comb = comb_ff;
    raw = '0;
    cd = '0;
    new_res = 1'b0;
    if (mod_stb) begin
      nxt_integ[0] = integ_ff[0] + ACC_W'(mod_bit);
      for (int i = 1; i < 3; i++) nxt_integ[i] = integ_ff[i] + integ_ff[i-1];
      nxt_dec = dec_ff + 9'd1;
      if (dec_ff == 9'((1 << lg) - 1)) begin
        nxt_dec = 9'd0;
        cd = integ_ff[2];
        for (int i = 0; i < 3; i++) begin
          nxt_comb[i] = cd;
          cd = cd - comb_ff[i];
        end
        raw = cd;
        if (settle_ff != `SDA_SETTLE - 2'd1) nxt_settle = settle_ff + 2'd1;
        new_res = (settle_ff == `SDA_SETTLE - 2'd1);
      end
    end
    if (hold) begin
      nxt_div = 8'd0;
      nxt_dec = 9'd0;
      nxt_settle = 2'd0;
      for (int i = 0; i < 3; i++) begin
        nxt_integ[i] = '0;
        nxt_comb[i] = '0;
      end
    end
  end

  // Scale full-scale density to 16 bits, then apply coding
  always_comb begin
    // Shortest decimation needs a left shift instead
    if (lg == 4'd5) scaled = 17'({raw[15:0], 1'b0});
    else scaled = 17'(raw >> (3 * lg - 16));
    if (scaled > 17'h0ffff) scaled = 17'h0ffff;
    if (setup_ff[`SDA_SET_UNI]) begin
      res_code = (scaled < 17'h08000) ? 16'h0000
                 : 16'({scaled[15:0], 1'b0} - 17'h10000);
      if (scaled[16] || scaled[15:0] == 16'hffff) res_code = 16'hffff;
    end else begin
      res_code = scaled[15:0];
    end
  end

  // Filter registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_ff <= 8'd0;
      dec_ff <= 9'd0;
      settle_ff <= 2'd0;
      for (int i = 0; i < 3; i++) begin
        integ_ff[i] <= '0;
        comb_ff[i] <= '0;
      end
    end else if (clk_en) begin
      div_ff <= nxt_div;
      dec_ff <= nxt_dec;
      settle_ff <= nxt_settle;
      integ_ff <= nxt_integ;
      comb_ff <= nxt_comb;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_rd_fall; fall && st_ff == sda_pkg::SDA_RD; endsequence
  sequence s_resync; rise && ser_in.din && ones_ff == 6'd31; endsequence
  property p_float; ser_in.cs_n |-> !ser_out.dout_oe; endproperty
  a_float: assert property (p_float) else $error("dout driven");
  property p_rd_bit;
    s_rd_fall |=> ser_out.dout == $past(out_sh_ff[23]);
  endproperty
  a_rd_bit: assert property (p_rd_bit) else $error("bad read bit");
  property p_resync; s_resync |=> st_ff == sda_pkg::SDA_IDLE
    && $stable(setup_ff) && $stable(clock_ff); endproperty
  a_resync: assert property (p_resync) else $error("no resync");
  property p_data_ready_n_set; new_res && clk_en |=> !data_ready_n; endproperty
  a_data_ready_n_set: assert property (p_data_ready_n_set) else $error("ready late");
  property p_data_ready_n_clr; rd_done && comm_ff[6:4] == `SDA_RS_DATA && !new_res
    |=> data_ready_n; endproperty
  a_data_ready_n_clr: assert property (p_data_ready_n_clr) else $error("ready stuck");
  property p_hold; hold && clk_en |=> integ_ff[2] == '0 && !new_res;
  endproperty
  a_hold: assert property (p_hold) else $error("filter not held");
  property p_mod; mod_stb |=> !mod_stb [*8]; endproperty
  a_mod: assert property (p_mod) else $error("modulator too fast");
  property p_uni; setup_ff[`SDA_SET_UNI] && scaled < 17'h08000
    |-> res_code == 16'h0000; endproperty
  a_uni: assert property (p_uni) else $error("unipolar floor");
  property p_idle_one; rise && st_ff == sda_pkg::SDA_IDLE && ser_in.din
    |=> st_ff == sda_pkg::SDA_IDLE; endproperty
  a_idle_one: assert property (p_idle_one) else $error("start on one");
endmodule : sda_ctrl

// *** sda_master.sv ***
// Behavioural serial master that talks to the converter port
`timescale 1ns/1ns
module sda_master (
  input  wire logic                  clk_sys,
  output sda_pkg::sda_ser_in_t       ser_in,
  input  wire sda_pkg::sda_ser_out_t ser_out
);
  logic miso;
  logic last_dout;

  // Track the last driven level so a released line reads back inverted
  always @(posedge clk_sys) begin
    if (ser_out.dout_oe) last_dout <= ser_out.dout;
  end
  assign miso = ser_out.dout_oe ? ser_out.dout : !last_dout;

  // Idle: deselected, clock parked high
  initial begin
    last_dout = 1'b0;
    ser_in    = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b1};
  end

  // Shift n bits MSB first; clock low and high for several cycles each
  task automatic shift(input int n, input logic [23:0] tx, input logic sel,
                       output logic [23:0] rx);
    rx = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk_sys);
      ser_in.cs_n = !sel;
      ser_in.sclk = 1'b0;
      ser_in.din  = tx[i];
      repeat (3) @(negedge clk_sys);
      ser_in.sclk = 1'b1;
      rx = {rx[22:0], miso};
      repeat (2) @(negedge clk_sys);
    end
  endtask : shift

  // Command byte then full-width transfer; test register never used
  task automatic access(input logic [7:0] cmd, input int n,
                        input logic [23:0] tx, output logic [23:0] rx);
    logic [23:0] junk;
    shift(8, {16'h0000, cmd}, 1'b1, junk);
    shift(n, tx, 1'b1, rx);
  endtask : access

  // Deselect between accesses
  task automatic release_cs();
    @(negedge clk_sys);
    ser_in.cs_n = 1'b1;
  endtask : release_cs
endmodule : sda_master

// *** sda_ctrl_test.sv ***
// Self-checking testbench of the converter control block
`timescale 1ns/1ns
module sda_ctrl_test;
  localparam int PER   = 8192;
  localparam int LIMIT = 80000;
  logic                  clk_sys;
  logic                  rst_b;
  logic                  mod_bit;
  logic                  data_ready_n;
  logic [1:0]            channel_select;
  logic [2:0]            gain_select;
  logic [1:0]            cal_mode;
  logic                  buffer_enable;
  logic                  power_down;
  logic                  clock_out_disable;
  sda_pkg::sda_ser_in_t  ser_in;
  sda_pkg::sda_ser_out_t ser_out;
  int                    miscompares;
  int                    check_count;
  int                    cycles;
  logic [23:0]           rx;

  sda_ctrl dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .ser_in(ser_in),
    .ser_out(ser_out), .mod_bit(mod_bit), .data_ready_n(data_ready_n),
    .channel_select(channel_select), .gain_select(gain_select),
    .cal_mode(cal_mode), .buffer_enable(buffer_enable),
    .power_down(power_down), .clock_out_disable(clock_out_disable)
  );
  sda_master m (.clk_sys(clk_sys), .ser_in(ser_in), .ser_out(ser_out));

  // Clock generator
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  // Power-up values read back through the port
  task automatic t_reset_values();
    m.access(8'h18, 8, 24'h0, rx);
    check("setup", rx, 24'h000001);
    m.access(8'h28, 8, 24'h0, rx);
    check("clock", rx, 24'h000005);
    m.access(8'h68, 24, 24'h0, rx);
    check("offset", rx, 24'h1f4000);
    m.access(8'h78, 24, 24'h0, rx);
    check("gain", rx, 24'h5761ab);
    m.release_cs();
  endtask : t_reset_values

  // Back-to-back writes and reads of the wide registers
  task automatic t_write_read();
    m.access(8'h60, 24, 24'h123456, rx);
    m.access(8'h70, 24, 24'hc3a501, rx);
    m.access(8'h68, 24, 24'h0, rx);
    check("offset wr", rx, 24'h123456);
    m.access(8'h78, 24, 24'h0, rx);
    check("gain wr", rx, 24'hc3a501);
  endtask : t_write_read

  // Ones start in the middle of a setup read, finish it, then resync in idle with select held low
  task automatic t_resync();
    logic [23:0] junk;
    m.shift(8, 24'h000018, 1'b1, junk);
    m.shift(4, 24'h000000, 1'b1, junk);
    m.shift(16, 24'hffffff, 1'b1, junk);
    m.shift(16, 24'hffffff, 1'b1, junk);
    m.access(8'h68, 24, 24'h0, rx);
    check("offset resync", rx, 24'h123456);
    m.release_cs();
  endtask : t_resync

  // Deselected traffic is ignored and the output is released
  task automatic t_deselected();
    m.shift(8, 24'h000060, 1'b0, rx);
    m.shift(24, 24'h00aaaa, 1'b0, rx);
    check("dout released", ser_out.dout_oe, 24'h0);
    m.access(8'h68, 24, 24'h0, rx);
    check("offset kept", rx, 24'h123456);
    m.release_cs();
    @(negedge clk_sys);
    check("oe after cs", ser_out.dout_oe, 24'h0);
  endtask : t_deselected

  // Control outputs follow the setup, clock and command bytes
  task automatic t_controls();
    m.access(8'h10, 8, 24'h0000ab, rx);
    m.access(8'h27, 8, 24'h0000fd, rx);
    check("cal mode", cal_mode, 24'h2);
    check("gain select", gain_select, 24'h5);
    check("buffer", buffer_enable, 24'h1);
    check("channel", channel_select, 24'h3);
    check("power down", power_down, 24'h1);
    check("clock out off", clock_out_disable, 24'h1);
    m.access(8'h2b, 8, 24'h0, rx);
    check("clock rd", rx, 24'h00001d);
    m.release_cs();
  endtask : t_controls

  // Synchronised conversion with a fixed stream density
  task automatic t_convert(input logic uni, input logic bit_v,
                           input logic [15:0] exp);
    int n;
    mod_bit = bit_v;
    m.access(8'h20, 8, 24'h000007, rx);
    m.access(8'h10, 8, {16'h0, 5'b00000, uni, 2'b01}, rx);
    m.access(8'h10, 8, {16'h0, 5'b00000, uni, 2'b00}, rx);
    n = 0;
    while (data_ready_n !== 1'b0 && n < 3 * PER + 1024) begin
      @(negedge clk_sys);
      n++;
    end
    check("settle not early", {23'h0, n >= 2 * PER}, 24'h1);
    check("ready low", data_ready_n, 24'h0);
    m.access(8'h38, 16, 24'h0, rx);
    check("result", rx, {8'h00, exp});
    @(negedge clk_sys);
    check("ready high", data_ready_n, 24'h1);
    m.release_cs();
  endtask : t_convert

  // Main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    cycles      = 0;
    mod_bit     = 1'b0;
    rst_b       = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset_values();
    t_write_read();
    t_resync();
    t_deselected();
    t_controls();
    t_convert(1'b0, 1'b1, 16'hffff);
    t_convert(1'b1, 1'b0, 16'h0000);
    summarize();
  end
endmodule : sda_ctrl_test
